//--- dv/csc_core_properties.sv
// Purpose: Port-level properties of the switch core
// Assumes: Merge straps held steady; ports 1, 2, 3, 10 and 0 watched
// Notes:   Strap age covers the two-flop sync
`timescale 1ns/1ps
module csc_core_chk
   import csc_pkg::*;
(
   // Clock and reset
   input wire logic                        SYS_CLK,
   input wire logic                        SYS_RST,
   // Ingress side
   input wire logic [NPORT/2-1:0]          MERGE_EN,
   input wire logic [NPORT-1:0]            ING_REQ,
   input wire logic [2*NPORT-1:0]          ING_REQ_CLASS,
   input wire logic [NPORT-1:0]            ING_GRANT,
   input wire logic [NCLS*CREDW*NPORT-1:0] ING_ADV_CRED,
   // Egress side
   input wire logic [NPORT-1:0]            EGR_RD_REQ,
   input wire logic [NPORT-1:0]            EGR_RD_VALID,
   input wire logic [NPORT-1:0]            EGR_RD_EOP
);
   logic [2:0]         age_reg;
   logic [2:0]         age_next;
   logic [NPORT/2-1:0] mer_reg;
   // Age restarts on any strap change
   assign age_next = (MERGE_EN != mer_reg) ? 3'h0 :
                     (&age_reg ? age_reg : age_reg + 3'h1);
   always_ff @(posedge SYS_CLK or posedge SYS_RST)
      if (SYS_RST)
         {age_reg, mer_reg} <= {3'h0, MERGE_EN};
      else
         {age_reg, mer_reg} <= {age_next, MERGE_EN};
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   a_grant_pulse: assert property (ING_GRANT[0] |=> !ING_GRANT[0])
      else $error("grant too long");
   a_grant_cause: assert property (ING_GRANT[0] |-> $past(ING_REQ[0])
      && $past(ING_REQ_CLASS[1:0]) != 2'h3) else $error("bad grant");
   a_odd_silent: assert property (age_reg >= 4 && MERGE_EN[1]
      |-> !ING_GRANT[3]) else $error("merged odd port granted");
   a_cred_x4: assert property (age_reg >= 4 && !MERGE_EN[5]
      |-> ING_ADV_CRED[510 +: 51] == {DCRED_PC_X4, HCRED_X4, DCRED_NP_X4,
      HCRED_X4, DCRED_PC_X4, HCRED_X4}) else $error("x4 credits wrong");
   a_cred_x8: assert property (age_reg >= 4 && MERGE_EN[1]
      |-> ING_ADV_CRED[102 +: 51] == {DCRED_PC_X8, HCRED_X8, DCRED_NP_X8,
      HCRED_X8, DCRED_PC_X8, HCRED_X8}) else $error("x8 credits wrong");
   a_rd_contig: assert property (EGR_RD_VALID[1] && !EGR_RD_EOP[1]
      |=> EGR_RD_VALID[1]) else $error("egress gap");
   a_rd_start: assert property ($rose(EGR_RD_VALID[1])
      |-> $past(EGR_RD_REQ[1])) else $error("read without request");
   a_eop_valid: assert property (EGR_RD_EOP[1] |-> EGR_RD_VALID[1])
      else $error("eop without word");
endmodule
bind csc_core csc_core_chk chk (.*);

//--- dv/csc_reader_model.sv
// Purpose: Link layer reader and acknowledger of one egress port
// Assumes: Started by a one-cycle go pulse while not busy
// Notes:   Packets of two words or more; ack after ack_dly cycles
`timescale 1ns/1ps
module csc_reader_model
   import csc_pkg::*;
(
   // Bench control
   input  wire logic          clk,
   input  wire logic          go,
   input  wire logic [1:0]    cls,
   input  wire logic [3:0]    ack_dly,
   output logic               busy,
   // Egress read side
   output logic               rd_req,
   output logic [1:0]         rd_cls,
   input  wire logic          rd_vld,
   input  wire logic [DW-1:0] rd_dat,
   input  wire logic          rd_eop,
   // Acknowledge side
   output logic               ack,
   output logic [1:0]         ack_cls
);
   logic [DW-1:0] got[$];
   int            n;
   // Words kept in order
   always @(posedge clk)
      if (rd_vld)
         got.push_back(rd_dat);
   // Request held until the first word
   initial
   begin
      {busy, rd_req, rd_cls, ack, ack_cls} = '0;
      forever
      begin
         @(posedge clk);
         if (go)
         begin
            #1 {busy, rd_req, rd_cls} = {2'b11, cls};
            for (n = 0; n < 300 && !rd_vld; n++) @(posedge clk);
            #1 {rd_req, rd_cls} = {1'b0, ~cls};
            for (n = 0; n < 300 && !(rd_vld && rd_eop); n++) @(posedge clk);
            repeat (ack_dly) @(posedge clk);
            #1 {ack, ack_cls} = {1'b1, cls};
            @(posedge clk);
            #1 {ack, busy} = 2'b00;
         end
      end
   end
endmodule

//--- dv/tb_top.sv
// Purpose: Self-checking bench of the switch core
// Assumes: Ports 2/3 merged; reader model on egress port 1
// Notes:   Small storage makes the fill case short
`timescale 1ns/1ps
module tb_top
   import csc_pkg::*;
;
   logic clk = 0, rst = 1, go = 0, g, p_req, p_ack;
   logic [1:0] gcls = 0, p_cls, p_acls;
   logic [3:0] dly = 0;
   logic [NPORT-1:0] req = 0, vld = 0, eop = 0, grant, rv, re;
   logic [2*NPORT-1:0] cls = 0;
   logic [DSCW*NPORT-1:0] desc = 0;
   logic [DW*NPORT-1:0] dat = 0, rdat;
   logic [NCLS*CREDW*NPORT-1:0] cred;
   logic [NCLS*NPORT-1:0] avail;
   logic [DW-1:0] exp_w[3][$];
   int nw[3][$];
   int seed = 70, err_total = 0, checked = 0;
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin \
   err_total++; $display("CHECK FAILED t=%0t %s", $time, m); end end
   initial forever #2 clk = ~clk;
   csc_core #(.WORDS_PC_P(32), .WORDS_NP_P(8)) dut (.SYS_CLK(clk),
      .SYS_RST(rst), .MERGE_EN(8'h02), .ING_REQ(req), .ING_REQ_CLASS(cls),
      .ING_REQ_DESC(desc), .ING_GRANT(grant), .ING_VALID(vld),
      .ING_DATA(dat), .ING_EOP(eop), .ING_ADV_CRED(cred),
      .EGR_VC_MAP({16{8'hf0}}), .EGR_AVAIL(avail),
      .EGR_RD_REQ({14'h0, p_req, 1'b0}), .EGR_RD_CLASS({28'h0, p_cls, 2'h0}),
      .EGR_RD_VALID(rv), .EGR_RD_DATA(rdat), .EGR_RD_EOP(re),
      .EGR_ACK({14'h0, p_ack, 1'b0}), .EGR_ACK_CLASS({28'h0, p_acls, 2'h0}));
   csc_reader_model rdr (.clk(clk), .go(go), .cls(gcls), .ack_dly(dly),
      .busy(), .rd_req(p_req), .rd_cls(p_cls), .rd_vld(rv[1]),
      .rd_dat(rdat[DW +: DW]), .rd_eop(re[1]), .ack(p_ack), .ack_cls(p_acls));
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Request, bounded wait for grant, stream words
   task automatic send(input int p, c, len, output logic ok);
      logic [DW-1:0] w;
      int n;
      n = (len + 19) / 20;
      @(posedge clk);
      #1 {req[p], cls[2*p +: 2]} = {1'b1, 2'(c)};
      desc[DSCW*p +: DSCW] = {4'h1, 1'(p > 3), 4'h0, 14'(len)};
      ok = 0;
      for (int t = 0; t < 40 && ok !== 1'b1; t++)
      begin
         @(posedge clk);
         ok = grant[p];
      end
      #1 req[p] = 0;
      if (ok !== 1'b1)
         return;
      nw[c].push_back(n);
      for (int i = 0; i < n; i++)
      begin
         repeat (5) w = {w[DW-33:0], $random(seed)};
         exp_w[c].push_back(w);
         {dat[DW*p +: DW], vld[p], eop[p]} = {w, 1'b1, 1'(i == n - 1)};
         @(posedge clk);
         #1;
      end
      {vld[p], eop[p]} = 2'b00;
   endtask
   // Read one packet of class c on port 1 and compare its words
   task automatic rd(input int c);
      int n, t;
      n = nw[c].pop_front();
      for (t = 0; t < 300 && (rdr.busy || avail[3 + c] !== 1'b1); t++)
         @(posedge clk);
      `CHK(avail[3 + c], 1'b1, "no packet waiting")
      #1 {gcls, go} = {2'(c), 1'b1};
      @(posedge clk);
      #1 go = 0;
      for (t = 0; t < 300 && rdr.got.size() < n; t++)
         @(posedge clk);
      repeat (n) `CHK(rdr.got.pop_front(), exp_w[c].pop_front(), "word")
   endtask
   initial
   begin
      repeat (5) @(posedge clk);
      #1 rst = 0;
      // Three classes, read back in reverse
      for (int c = 0; c < 3; c++)
      begin
         send(4 * c, c, 20 * c + 41, g);
         `CHK(g, 1'b1, "class grant")
      end
      for (int c = 2; c >= 0; c--)
         rd(c);
      $display("test classes done");
      // Class 3 and merged odd port refused
      send(5, 3, 40, g);
      `CHK(g, 1'b0, "class 3 granted")
      send(3, 0, 40, g);
      `CHK(g, 1'b0, "odd port granted")
      $display("test refusals done");
      // Fill until refused, drain, retry
      dly = 4'h5;
      for (int i = 0; i < 5; i++)
      begin
         send(6, 1, 60, g);
         `CHK(g, 1'(i < 4), "fill grant")
      end
      repeat (4) rd(1);
      send(6, 1, 60, g);
      `CHK(g, 1'b1, "retry grant")
      rd(1);
      $display("test fill done");
      report_and_stop();
   end
endmodule

//--- src/csc_core.sv
// Purpose: Switch core: ingress queues, 16x16 crossbar, egress queues
// Assumes: Port logic on SYS_CLK; merge straps come from pins
// Notes:   Store-and-forward at ingress; egress keeps a replay pool
//
// Behaviour
// [R1] Every port owns its own ingress and egress buffer.
// [R2] Ingress takes link packets and port-generated packets alike.
// [R3] Port routes and maps first; descriptor is stored with packet.
// [R4] Three ingress queues: posted, non-posted, completion, by type.
// [R5] Queues hold descriptors and payload in separate memories.
// [R6] x4 ingress: 6176/1024/6176 bytes, 64 packets, credits 386/64/386.
// [R7] x8 ingress: 12352/2048/12352 bytes, 127 packets, credits 772/128.
// [R8] Merged pair pools both ports' memories, ingress and egress.
// [R9] Packets cross only after ordering and arbitration.
// [R10] Egress accepts packets regardless of egress link credits.
// [R11] Egress port's TC to VC map applies on entry to egress.
// [R12] Egress keeps separate posted, non-posted, completion queues.
// [R13] x4 egress: 6176/1024/6176 bytes, 64 packets each.
// [R14] x8 egress: 12352/2048/12352 bytes, 128 packets each.
// [R15] Egress space doubles as replay store, freed on acknowledge.
// [R16] Replay holds at most 32 packets x4, 64 packets x8.
// [R17] Crossbar joins all 16 ingress to 16 egress concurrently.
// [R18] Each port has one ingress and one egress data interface.
// [R19] All data paths are 160 bits wide.
// [R20] A crossing packet runs contiguously, never interleaved.
// [R21] Ingress rate is set by the port's mode, width and speed.
// [R22] Link layer reads the chosen packet from its egress buffer.
// [R23] Merged odd port vanishes; its resources serve the even port.
// [R24] A packet waits in ingress until egress has room; no drops.
// [R25] Queues count bytes and packets; full when either limit hits.
`timescale 1ns/1ps
module csc_core
   import csc_pkg::*;
#(
   parameter int WORDS_PC_P = WORDS_PC,
   parameter int WORDS_NP_P = WORDS_NP
)(
   // Clock and reset
   input  wire logic                      SYS_CLK,
   input  wire logic                      SYS_RST,
   // Merge straps, one per even/odd pair
   input  wire logic [NPORT/2-1:0]        MERGE_EN,
   // Ingress packet request
   input  wire logic [NPORT-1:0]          ING_REQ,
   input  wire logic [2*NPORT-1:0]        ING_REQ_CLASS,
   input  wire logic [DSCW*NPORT-1:0]     ING_REQ_DESC,
   output logic      [NPORT-1:0]          ING_GRANT,
   // Ingress payload words
   input  wire logic [NPORT-1:0]          ING_VALID,
   input  wire logic [DW*NPORT-1:0]       ING_DATA,
   input  wire logic [NPORT-1:0]          ING_EOP,
   // Advertised ingress credits
   output logic      [NCLS*CREDW*NPORT-1:0] ING_ADV_CRED,
   // Egress TC to VC map, one bit per TC
   input  wire logic [8*NPORT-1:0]        EGR_VC_MAP,
   // Egress link layer reader
   output logic      [NCLS*NPORT-1:0]     EGR_AVAIL,
   input  wire logic [NPORT-1:0]          EGR_RD_REQ,
   input  wire logic [2*NPORT-1:0]        EGR_RD_CLASS,
   output logic      [NPORT-1:0]          EGR_RD_VALID,
   output logic      [DW*NPORT-1:0]       EGR_RD_DATA,
   output logic      [NPORT-1:0]          EGR_RD_EOP,
   // Replay acknowledge
   input  wire logic [NPORT-1:0]          EGR_ACK,
   input  wire logic [2*NPORT-1:0]        EGR_ACK_CLASS
);
   logic [NPORT/2-1:0] mrg_s1_reg;
   logic [NPORT/2-1:0] mrg_reg;
   logic [NPORT-1:0]   x8;
   logic [NPORT-1:0]   off;
   logic [NCLS-1:0]    ifit  [NPORT];
   logic [NCLS-1:0]    ihv   [NPORT];
   logic [NCLS-1:0]    ireop [NPORT];
   logic [DSCW-1:0]    ihd   [NPORT][NCLS];
   logic [DW-1:0]      ird   [NPORT][NCLS];
   logic [NCLS-1:0]    efit  [NPORT];
   logic [NCLS-1:0]    ehv   [NPORT];
   logic [NCLS-1:0]    ereop [NPORT];
   logic [DSCW-1:0]    ehd   [NPORT][NCLS];
   logic [DW-1:0]      erd   [NPORT][NCLS];
   logic [7:0]         eun   [NPORT][NCLS];
   logic [NPORT-1:0]   gnt;
   logic [NPORT-1:0]   cand_v;
   logic [1:0]         cand_c [NPORT];
   logic [PIDW-1:0]    cand_d [NPORT];
   logic [NPORT-1:0]   ibusy;
   logic [1:0]         icls   [NPORT];
   logic [NPORT-1:0]   xreq   [NPORT];
   logic [PIDW:0]      xpick  [NPORT];
   logic [NPORT-1:0]   xstart;
   logic [NPORT-1:0]   xbusy_reg;
   logic [PIDW-1:0]    xsrc_reg [NPORT];
   logic [1:0]         xcls_reg [NPORT];
   logic [PIDW-1:0]    rr_reg   [NPORT];
   logic [NPORT-1:0]   rpop;
   logic [NPORT-1:0]   reop;
   logic [DW-1:0]      rdat [NPORT];

   // Byte limit of a class in a mode
   function automatic logic [LENW-1:0] lim_bytes(input int c,
                                                 input logic m8);
      if (c == int'(CLS_NP))
         return m8 ? BYTES_NP_X8 : BYTES_NP_X4;
      return m8 ? BYTES_PC_X8 : BYTES_PC_X4;
   endfunction

   // Round robin: first request after the last winner
   function automatic logic [PIDW:0] rr_pick(input logic [NPORT-1:0] req,
                                             input logic [PIDW-1:0] last);
      logic [PIDW:0]   r;
      logic [PIDW-1:0] i;
      r = '0;
      for (int k = NPORT; k >= 1; k--)
      begin
         i = last + PIDW'(k);
         if (req[i])
            r = {1'b1, i};
      end
      return r;
   endfunction

   // ======================================================
   // Merge straps come from pins, so two flops first
   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         mrg_s1_reg <= '0;
         mrg_reg    <= '0;
      end
      else
      begin
         mrg_s1_reg <= MERGE_EN;
         mrg_reg    <= mrg_s1_reg;
      end
   end

   // ======================================================
   // Per port buffers; generate gives each port its own set [R1]
   for (genvar p = 0; p < NPORT; p++)
   begin : g_port
      csc_st_t    st_reg;
      logic [1:0] icl_reg;
      logic [1:0] rcl;
      logic       rstart;
      logic       ract_reg;
      logic [1:0] rcl_reg;
      logic [1:0] rcls;
      logic [7:0] rpl;

      assign x8[p]  = mrg_reg[p/2];
      assign off[p] = x8[p] && (p % 2 == 1);           // [R23]
      assign rcl    = ING_REQ_CLASS[2*p +: 2];
      // Local and link packets take the same path [R2]
      // Grant only when the class queue can hold the packet [R24]
      assign gnt[p] = ING_REQ[p] && (st_reg == ST_IDLE) && !off[p]
                   && (rcl != 2'h3) && ifit[p][rcl];

      // Words arrive at the pace the port sets [R21]
      always_ff @(posedge SYS_CLK or posedge SYS_RST)
      begin
         if (SYS_RST)
         begin
            st_reg  <= ST_IDLE;
            icl_reg <= CLS_PT;
         end
         else
         begin
            case (st_reg)
               ST_IDLE:
                  if (gnt[p])
                  begin
                     st_reg  <= ST_BUSY;
                     icl_reg <= rcl;
                  end
               ST_BUSY:
                  if (ING_VALID[p] && ING_EOP[p])
                     st_reg <= ST_IDLE;
               default:
                  st_reg <= ST_IDLE;
            endcase
         end
      end

      // Egress reader: one packet at a time, every cycle [R22]
      assign rpl  = 8'(eun[p][0] + eun[p][1] + eun[p][2]);
      assign rcls = ract_reg ? rcl_reg : EGR_RD_CLASS[2*p +: 2];
      // New packet only while the replay store has a slot [R16]
      assign rstart = EGR_RD_REQ[p] && !ract_reg && (rcls != 2'h3)
                   && ehv[p][rcls] && (rpl < (x8[p] ? RPLY_X8 : RPLY_X4));
      assign rpop[p] = rstart || ract_reg;
      assign reop[p] = ereop[p][rcls];
      assign rdat[p] = erd[p][rcls];

      always_ff @(posedge SYS_CLK or posedge SYS_RST)
      begin
         if (SYS_RST)
         begin
            ract_reg <= 1'b0;
            rcl_reg  <= CLS_PT;
         end
         else
         begin
            if (rstart)
               rcl_reg <= rcls;
            if (rpop[p])
               ract_reg <= !reop[p];
         end
      end

      // Queues by transaction type, sized by port mode [R4] [R12]
      for (genvar c = 0; c < NCLS; c++)
      begin : g_cls
         // Merged mode pools both ports' storage [R6] [R7] [R8]
         csc_queue #(
            .DEPTH (c == 1 ? WORDS_NP_P : WORDS_PC_P),
            .PKTS  (QPKTS)
         ) u_ing (
            .clk      (SYS_CLK),
            .rst      (SYS_RST),
            .byte_lim (lim_bytes(c, x8[p])),
            .pkt_lim  (x8[p] ? IPKT_X8 : IPKT_X4),
            .retain   (1'b0),
            .adm_desc (ING_REQ_DESC[DSCW*p +: DSCW]),     // [R3]
            .adm_fit  (ifit[p][c]),
            .adm_go   (gnt[p] && rcl == 2'(c)),
            .wr_en    (st_reg == ST_BUSY && ING_VALID[p]
                       && icl_reg == 2'(c)),
            .wr_data  (ING_DATA[DW*p +: DW]),
            .wr_eop   (ING_EOP[p]),
            .hd_valid (ihv[p][c]),
            .hd_desc  (ihd[p][c]),
            .rd_en    (ibusy[p] && icls[p] == 2'(c)),
            .rd_data  (ird[p][c]),
            .rd_eop   (ireop[p][c]),
            .rel_en   (1'b0),
            .unacked  ()
         );
         // Egress retains sent packets until acknowledged [R13] [R14]
         csc_queue #(
            .DEPTH (c == 1 ? WORDS_NP_P : WORDS_PC_P),
            .PKTS  (QPKTS)
         ) u_egr (
            .clk      (SYS_CLK),
            .rst      (SYS_RST),
            .byte_lim (lim_bytes(c, x8[p])),
            .pkt_lim  (x8[p] ? EPKT_X8 : EPKT_X4),
            .retain   (1'b1),                             // [R15]
            .adm_desc (ehd[p][c]),
            .adm_fit  (efit[p][c]),
            .adm_go   (xstart[p] && cand_c[xpick[p][PIDW-1:0]] == 2'(c)),
            .wr_en    (xbusy_reg[p] && xcls_reg[p] == 2'(c)),
            .wr_data  (ird[xsrc_reg[p]][xcls_reg[p]]),
            .wr_eop   (ireop[xsrc_reg[p]][xcls_reg[p]]),
            .hd_valid (ehv[p][c]),
            .hd_desc  (),
            .rd_en    (rpop[p] && rcls == 2'(c)),
            .rd_data  (erd[p][c]),
            .rd_eop   (ereop[p][c]),
            .rel_en   (EGR_ACK[p] && EGR_ACK_CLASS[2*p +: 2] == 2'(c)),
            .unacked  (eun[p][c])
         );
         // Egress port's own TC to VC map rewrites the VC field [R11]
         assign ehd[p][c] = {ihd[xpick[p][PIDW-1:0]][c][DSCW-1:DSC_LOC_LSB],
            EGR_VC_MAP[8*p + int'(ihd[xpick[p][PIDW-1:0]][c]
                                  [DSC_TC_LSB +: 3])],
            ihd[xpick[p][PIDW-1:0]][c][DSC_VC_LSB-1:0]};
      end
   end

   // ======================================================
   // Ingress side of the crossbar: which port is sending, which class
   always_comb
   begin
      ibusy = '0;
      for (int s = 0; s < NPORT; s++)
         icls[s] = CLS_PT;
      for (int d = 0; d < NPORT; d++)
         if (xbusy_reg[d])
         begin
            ibusy[xsrc_reg[d]] = 1'b1;
            icls[xsrc_reg[d]]  = xcls_reg[d];
         end
   end

   // Ordering pick per port: posted first, then completion [R9]
   always_comb
   begin
      for (int s = 0; s < NPORT; s++)
      begin
         cand_v[s] = (ihv[s] != '0) && !ibusy[s];
         cand_c[s] = CLS_PT;
         if (ihv[s][CLS_NP])
            cand_c[s] = CLS_NP;
         if (ihv[s][CLS_CP])
            cand_c[s] = CLS_CP;
         if (ihv[s][CLS_PT])
            cand_c[s] = CLS_PT;
         cand_d[s] = ihd[s][cand_c[s]][DSC_DST_LSB +: PIDW];
         if (off[cand_d[s]])
            cand_v[s] = 1'b0;
      end
   end

   // Egress arbiters; distinct pairs run at once [R17] [R18] [R19]
   for (genvar d = 0; d < NPORT; d++)
   begin : g_xbar
      always_comb
      begin
         for (int s = 0; s < NPORT; s++)
            xreq[d][s] = cand_v[s] && (cand_d[s] == PIDW'(d));
      end
      assign xpick[d] = rr_pick(xreq[d], rr_reg[d]);
      // No link credit term: egress may fill while congested [R10]
      assign xstart[d] = !xbusy_reg[d] && xpick[d][PIDW]
                      && efit[d][cand_c[xpick[d][PIDW-1:0]]];     // [R24]

      // Path stays owned until the last word has crossed [R20]
      always_ff @(posedge SYS_CLK or posedge SYS_RST)
      begin
         if (SYS_RST)
         begin
            xbusy_reg[d] <= 1'b0;
            xsrc_reg[d]  <= '0;
            xcls_reg[d]  <= CLS_PT;
            rr_reg[d]    <= '0;
         end
         else if (xstart[d])
         begin
            xbusy_reg[d] <= 1'b1;
            xsrc_reg[d]  <= xpick[d][PIDW-1:0];
            xcls_reg[d]  <= cand_c[xpick[d][PIDW-1:0]];
            rr_reg[d]    <= xpick[d][PIDW-1:0];
         end
         else if (xbusy_reg[d] && ireop[xsrc_reg[d]][xcls_reg[d]])
            xbusy_reg[d] <= 1'b0;
      end
   end

   // ======================================================
   // Registered outputs
   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         ING_GRANT    <= '0;
         ING_ADV_CRED <= '0;
         EGR_AVAIL    <= '0;
         EGR_RD_VALID <= '0;
         EGR_RD_DATA  <= '0;
         EGR_RD_EOP   <= '0;
      end
      else
      begin
         ING_GRANT    <= gnt;
         EGR_RD_VALID <= rpop;
         EGR_RD_EOP   <= rpop & reop;
         for (int p = 0; p < NPORT; p++)
         begin
            EGR_AVAIL[NCLS*p +: NCLS]  <= ehv[p];
            EGR_RD_DATA[DW*p +: DW]    <= rdat[p];
            // Order {cp, np, pt}, each {data, header} [R6] [R7]
            ING_ADV_CRED[NCLS*CREDW*p +: NCLS*CREDW] <= x8[p]
               ? {DCRED_PC_X8, HCRED_X8, DCRED_NP_X8, HCRED_X8,
                  DCRED_PC_X8, HCRED_X8}
               : {DCRED_PC_X4, HCRED_X4, DCRED_NP_X4, HCRED_X4,
                  DCRED_PC_X4, HCRED_X4};
         end
      end
   end
endmodule

//--- src/csc_pkg.sv
// Purpose: Shared constants and types of the switch core buffers
// Assumes: One core clock; ports hand over routed descriptors
// Notes:   Byte and packet limits are per queue and per port mode
package csc_pkg;
   // ======================================================
   // Geometry
   localparam int NPORT          = 16;
   localparam int PIDW           = 4;
   localparam int DW             = 160;
   localparam int NCLS           = 3;
   localparam int LENW           = 14;
   localparam int BYTES_PER_WORD = 20;
   // Transaction classes
   localparam logic [1:0] CLS_PT = 2'h0;
   localparam logic [1:0] CLS_NP = 2'h1;
   localparam logic [1:0] CLS_CP = 2'h2;
   // Descriptor layout
   localparam int DSC_LEN_LSB = 0;
   localparam int DSC_TC_LSB  = 14;
   localparam int DSC_VC_LSB  = 17;
   localparam int DSC_LOC_LSB = 18;
   localparam int DSC_DST_LSB = 19;
   localparam int DSCW        = 23;
   // ======================================================
   // Queue byte limits
   localparam logic [LENW-1:0] BYTES_PC_X4 = 14'h1820;
   localparam logic [LENW-1:0] BYTES_NP_X4 = 14'h0400;
   localparam logic [LENW-1:0] BYTES_PC_X8 = 14'h3040;
   localparam logic [LENW-1:0] BYTES_NP_X8 = 14'h0800;
   // Packet limits
   localparam logic [7:0] IPKT_X4 = 8'h40;
   localparam logic [7:0] IPKT_X8 = 8'h7f;
   localparam logic [7:0] EPKT_X4 = 8'h40;
   localparam logic [7:0] EPKT_X8 = 8'h80;
   localparam logic [7:0] RPLY_X4 = 8'h20;
   localparam logic [7:0] RPLY_X8 = 8'h40;
   // Advertised credits, per class {data, header}
   localparam int CREDW = 17;
   localparam logic [9:0] DCRED_PC_X4 = 10'h182;
   localparam logic [9:0] DCRED_NP_X4 = 10'h040;
   localparam logic [9:0] DCRED_PC_X8 = 10'h304;
   localparam logic [9:0] DCRED_NP_X8 = 10'h080;
   localparam logic [6:0] HCRED_X4    = 7'h40;
   localparam logic [6:0] HCRED_X8    = 7'h7f;
   // Storage words sized for the merged pool
   localparam int WORDS_PC = (12352 + BYTES_PER_WORD - 1) / BYTES_PER_WORD;
   localparam int WORDS_NP = (2048 + BYTES_PER_WORD - 1) / BYTES_PER_WORD;
   localparam int QPKTS    = 128;
   // Ingress packet state
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} csc_st_t;
endpackage

//--- src/csc_queue.sv
// Purpose: One transaction queue: descriptor ring plus data ring
// Assumes: Admission is checked before the first word is written
// Notes:   With retain set, read packets stay until released
`timescale 1ns/1ps
module csc_queue
   import csc_pkg::*;
#(
   parameter int DEPTH = WORDS_PC,
   parameter int PKTS  = QPKTS
)(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // Limits of the current mode
   input  wire logic [LENW-1:0] byte_lim,
   input  wire logic [7:0]      pkt_lim,
   input  wire logic            retain,
   // Admission
   input  wire logic [DSCW-1:0] adm_desc,
   output logic                 adm_fit,
   input  wire logic            adm_go,
   // Word write
   input  wire logic            wr_en,
   input  wire logic [DW-1:0]   wr_data,
   input  wire logic            wr_eop,
   // Head and word read
   output logic                 hd_valid,
   output logic [DSCW-1:0]      hd_desc,
   input  wire logic            rd_en,
   output logic [DW-1:0]        rd_data,
   output logic                 rd_eop,
   // Release of retained packets
   input  wire logic            rel_en,
   output logic [7:0]           unacked
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = $clog2(PKTS) + 1;

   logic [DW:0]     mem [DEPTH];
   logic [DSCW-1:0] dsc [PKTS];
   logic [AW-1:0]   wp_reg;
   logic [AW-1:0]   rp_reg;
   logic [PW-1:0]   dwp_reg;
   logic [PW-1:0]   dcp_reg;
   logic [PW-1:0]   drp_reg;
   logic [PW-1:0]   dfp_reg;
   logic [LENW:0]   bytes_reg;
   logic [LENW:0]   bytes_next;
   logic [AW:0]     words_reg;
   logic [AW:0]     words_next;
   logic [LENW-1:0] adm_len;
   logic [LENW-1:0] rel_len;
   logic [PW-1:0]   pkts_used;
   logic            rel_ok;

   // Words a packet of len bytes occupies
   function automatic logic [AW:0] words_of(input logic [LENW-1:0] len);
      logic [LENW:0] t;
      t = {1'b0, len} + (LENW+1)'(BYTES_PER_WORD - 1);
      return (AW+1)'(t / (LENW+1)'(BYTES_PER_WORD));
   endfunction

   // Ring pointer step; depth need not be a power of two
   function automatic logic [AW-1:0] adv(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   // ======================================================
   // Occupancy and admission
   assign adm_len   = adm_desc[DSC_LEN_LSB +: LENW];
   assign rel_len   = dsc[dfp_reg[PW-2:0]][DSC_LEN_LSB +: LENW];
   assign pkts_used = dwp_reg - dfp_reg;
   // Full on packet count, bytes or words, whichever first [R25]
   assign adm_fit = (8'(pkts_used) < pkt_lim)
                 && ({1'b0, adm_len} + bytes_reg <= {1'b0, byte_lim})
                 && (words_of(adm_len) + words_reg <= (AW+1)'(DEPTH));
   // Only fully stored packets are offered downstream
   assign hd_valid = (dcp_reg != drp_reg);
   assign hd_desc  = dsc[drp_reg[PW-2:0]];
   assign rd_data  = mem[rp_reg][DW-1:0];
   assign rd_eop   = mem[rp_reg][DW];
   assign unacked  = 8'(drp_reg - dfp_reg);
   // Retained packets free on release, others on their last read [R15]
   assign rel_ok = retain ? (rel_en && (drp_reg != dfp_reg))
                          : (rd_en && rd_eop);
   assign bytes_next = bytes_reg + (adm_go ? {1'b0, adm_len} : '0)
                     - (rel_ok ? {1'b0, rel_len} : '0);
   assign words_next = words_reg + (adm_go ? words_of(adm_len) : '0)
                     - (rel_ok ? words_of(rel_len) : '0);

   // ======================================================
   // Storage: descriptors and payload kept apart [R5]
   always_ff @(posedge clk)
   begin
      if (wr_en)
         mem[wp_reg] <= {wr_eop, wr_data};
      if (adm_go)
         dsc[dwp_reg[PW-2:0]] <= adm_desc;
   end

   // Pointers and counts
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wp_reg    <= '0;
         rp_reg    <= '0;
         dwp_reg   <= '0;
         dcp_reg   <= '0;
         drp_reg   <= '0;
         dfp_reg   <= '0;
         bytes_reg <= '0;
         words_reg <= '0;
      end
      else
      begin
         bytes_reg <= bytes_next;
         words_reg <= words_next;
         if (wr_en)
            wp_reg <= adv(wp_reg);
         if (rd_en)
            rp_reg <= adv(rp_reg);
         if (adm_go)
            dwp_reg <= dwp_reg + 1'b1;
         if (wr_en && wr_eop)
            dcp_reg <= dcp_reg + 1'b1;
         if (rd_en && rd_eop)
            drp_reg <= drp_reg + 1'b1;
         if (rel_ok)
            dfp_reg <= dfp_reg + 1'b1;
      end
   end
endmodule
